// ### logic/pcch_host.sv
// Host end: issues clear commands on the pins under AXI4-Lite control
`timescale 1ns/1ps
`default_nettype none
module pcch_host
    import pcch_pkg::*;
#(
    parameter int SETUP_CYCLES = pcch_pkg::SETUP_CYC,
    parameter int HOLD_CYCLES = pcch_pkg::HOLD_CYC
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Interrupt
    output logic irq,
    // Link
    pcch_if.host lnk
);
    import pcch_pkg::*;

    typedef enum logic [3:0] {
        PH_IDLE = 4'b0001,
        PH_SETUP = 4'b0010,
        PH_TRIG = 4'b0100,
        PH_REL = 4'b1000
    } pcch_hstate_t;

    pcch_hstate_t state_r;
    logic [PIN_IN_W-1:0] pins_s;
    logic s_run, s_ready, s_busy, s_judge, s_strobe, s_error;
    logic [DATA_W-1:0] s_data;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic aw_have_r, w_have_r, wr_go, wr_ok;
    logic wstrb0_r;
    logic [1:0] cmd_r;
    logic hold_mode_r;
    logic [IRQ_W-1:0] irq_stat_r, irq_mask_r, irq_set;
    logic start, refuse, ack;
    logic [CNT_W-1:0] cnt_r;
    logic [6:0] code_r;
    logic trig_r;

    pcch_sync #(.W(PIN_IN_W)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d({lnk.run, lnk.ready, lnk.busy, lnk.judge, lnk.strobe,
            lnk.error, lnk.result_data_outputs}),
        .q(pins_s)
    );
    assign {s_run, s_ready, s_busy, s_judge, s_strobe, s_error, s_data}
        = pins_s;

    // Write channel: address and data taken in either order
    assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
    assign wr_ok = awaddr_r == ADDR_CTRL || awaddr_r == ADDR_IRQ_STAT
        || awaddr_r == ADDR_IRQ_MASK || awaddr_r == ADDR_STATUS
        || awaddr_r == ADDR_DATA;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb0_r <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_have_r && !s_axi_awready;
            s_axi_wready <= !w_have_r && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb0_r <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= RESP_OKAY;
                unique case (s_axi_araddr)
                    ADDR_CTRL: s_axi_rdata <= 32'({hold_mode_r, 2'h0, cmd_r});
                    ADDR_STATUS: s_axi_rdata <= 32'({state_r != PH_IDLE,
                        s_run, s_ready, s_busy, s_judge, s_strobe, s_error});
                    ADDR_IRQ_STAT: s_axi_rdata <= 32'(irq_stat_r);
                    ADDR_IRQ_MASK: s_axi_rdata <= 32'(irq_mask_r);
                    ADDR_DATA: s_axi_rdata <= 32'(s_data);
                    default: begin
                        s_axi_rdata <= '0;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Control register; a command write starts a sequence when idle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_r <= CMD_NONE;
            hold_mode_r <= 1'b0;
            irq_mask_r <= '0;
        end else if (wr_go && wstrb0_r) begin
            // Running command keeps its ack selection until it ends
            if (awaddr_r == ADDR_CTRL && state_r == PH_IDLE) begin
                cmd_r <= wdata_r[CTRL_CMD_LSB +: 2];
                hold_mode_r <= wdata_r[CTRL_HOLD_BIT];
            end
            if (awaddr_r == ADDR_IRQ_MASK) begin
                irq_mask_r <= wdata_r[IRQ_W-1:0];
            end
        end
    end

    assign start = wr_go && wstrb0_r && awaddr_r == ADDR_CTRL
        && state_r == PH_IDLE && wdata_r[CTRL_CMD_LSB +: 2] != CMD_NONE;
    // Outputs clear needs ready, no busy, no strobe; other clears need ready, no busy
    assign refuse = start && (!s_ready || s_busy
        || (wdata_r[CTRL_CMD_LSB +: 2] == CMD_OUT && s_strobe));

    // Acknowledge for the running command: seen on the pins, or the hold count for a measurement clear in hold mode
    always_comb begin
        unique case (cmd_r)
            CMD_MEAS: ack = hold_mode_r ? cnt_r == CNT_W'(HOLD_CYCLES - 1)
                : s_busy;
            CMD_OUT: ack = !s_judge || s_data == '0;
            CMD_ERR: ack = !s_error;
            default: ack = 1'b1;
        endcase
    end

    // Pin sequence: code, wait, trigger, acknowledge, drop, release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= PH_IDLE;
            cnt_r <= '0;
            code_r <= CODE_NONE;
            trig_r <= 1'b0;
        end else begin
            unique case (state_r)
                PH_IDLE: begin
                    cnt_r <= '0;
                    if (start && !refuse) begin
                        state_r <= PH_SETUP;
                        unique case (wdata_r[CTRL_CMD_LSB +: 2])
                            CMD_MEAS: code_r <= CODE_MEAS_CLR;
                            CMD_OUT: code_r <= CODE_OUT_CLR;
                            default: code_r <= CODE_ERR_CLR;
                        endcase
                    end
                end
                PH_SETUP: begin
                    if (cnt_r == CNT_W'(SETUP_CYCLES - 1)) begin
                        state_r <= PH_TRIG;
                        cnt_r <= '0;
                        trig_r <= 1'b1;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                PH_TRIG: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (ack) begin
                        state_r <= PH_REL;
                        trig_r <= 1'b0;
                    end
                end
                PH_REL: begin
                    state_r <= PH_IDLE;
                    code_r <= CODE_NONE;
                end
            endcase
        end
    end

    // Sticky events: set beats a write-one clear
    assign irq_set = IRQ_W'({refuse, state_r == PH_REL} << 0);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_r <= '0;
            irq <= 1'b0;
        end else begin
            if (wr_go && wstrb0_r && awaddr_r == ADDR_IRQ_STAT) begin
                irq_stat_r <= (irq_stat_r & ~wdata_r[IRQ_W-1:0]) | irq_set;
            end else begin
                irq_stat_r <= irq_stat_r | irq_set;
            end
            irq <= |(irq_stat_r & irq_mask_r);
        end
    end

    assign lnk.command_code_inputs = code_r;
    assign lnk.command_execute_trigger = trig_r;
endmodule
`default_nettype wire

// ### logic/pcch_pkg.sv
// Constants shared by both ends of the parallel clear command link
// Behaviour
// - Run output on in run screen
// - Measurement clear code: only input 6 on
// - Outputs clear code: inputs 1 and 6 on
// - Error clear code: inputs 0 and 6 on
// - Host sets code, triggers after over 1 ms
// - Busy about 1 ms during measurement clear
// - Ready low during measurement clear and busy
// - Host: see busy, drop trigger, release code
// - Host holds trigger 5 ms if blind
// - Outputs clear turns judgement and data off
// - Outputs clear leaves ready, busy, strobe
// - No outputs clear while unready, busy, strobe
// - Host: see outputs off, drop trigger, release
// - Error clear leaves all other outputs alone
// - No error clear while unready or busy
// - Host: see error off, drop trigger, release
package pcch_pkg;
    localparam int CODE_W = 7;
    localparam int DATA_W = 16;
    localparam logic [6:0] CODE_MEAS_CLR = 7'h40;
    localparam logic [6:0] CODE_OUT_CLR = 7'h42;
    localparam logic [6:0] CODE_ERR_CLR = 7'h41;
    localparam logic [6:0] CODE_NONE = 7'h00;
    localparam int CLK_PS = 5000;
    localparam longint SETUP_PS = 64'h0000_0000_3B9A_CA00;
    localparam longint BUSY_PS = 64'h0000_0000_3B9A_CA00;
    localparam longint HOLD_PS = 64'h0000_0001_2A05_F200;
    // Least time rounds up, then one more cycle for "over"
    localparam int SETUP_CYC = int'((SETUP_PS + CLK_PS - 1) / CLK_PS) + 1;
    localparam int BUSY_CYC = int'(BUSY_PS / CLK_PS);
    localparam int HOLD_CYC = int'((HOLD_PS + CLK_PS - 1) / CLK_PS);
    localparam int CNT_W = 21;
    localparam int PIN_IN_W = 22;
    localparam logic [1:0] CMD_NONE = 2'h0;
    localparam logic [1:0] CMD_MEAS = 2'h1;
    localparam logic [1:0] CMD_OUT = 2'h2;
    localparam logic [1:0] CMD_ERR = 2'h3;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
    localparam logic [7:0] ADDR_DATA = 8'h10;
    localparam int CTRL_CMD_LSB = 0;
    localparam int CTRL_HOLD_BIT = 4;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_REFUSED_BIT = 1;
    localparam int IRQ_W = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### logic/pcch_if.sv
// Parallel pin bundle between controller host and device
`timescale 1ns/1ps
`default_nettype none
interface pcch_if;
    import pcch_pkg::*;
    logic [CODE_W-1:0] command_code_inputs;
    logic command_execute_trigger;
    logic run;
    logic ready;
    logic busy;
    logic judge;
    logic [DATA_W-1:0] result_data_outputs;
    logic strobe;
    logic error;
    modport dev (
        input command_code_inputs, command_execute_trigger,
        output run, ready, busy, judge, result_data_outputs, strobe, error
    );
    modport host (
        output command_code_inputs, command_execute_trigger,
        input run, ready, busy, judge, result_data_outputs, strobe, error
    );
endinterface
`default_nettype wire

// ### logic/pcch_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module pcch_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    meta_r[i] <= 1'b0;
                    q[i] <= 1'b0;
                end else begin
                    meta_r[i] <= d[i];
                    q[i] <= meta_r[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ### logic/pcch_device.sv
// Device end: decodes clear commands and drives status pins
`timescale 1ns/1ps
`default_nettype none
module pcch_device
    import pcch_pkg::*;
#(
    parameter int BUSY_CYCLES = pcch_pkg::BUSY_CYC
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Link
    pcch_if.dev lnk,
    // Measurement side
    input wire logic run_screen,
    input wire logic res_load,
    input wire logic res_judge,
    input wire logic [pcch_pkg::DATA_W-1:0] res_data,
    input wire logic res_strobe,
    input wire logic err_raise,
    output logic meas_clear
);
    import pcch_pkg::*;

    typedef enum logic [1:0] {
        PD_IDLE = 2'b01,
        PD_BUSY = 2'b10
    } pcch_dstate_t;

    pcch_dstate_t state_r;
    logic [CODE_W:0] pins_s;
    logic trig_d_r, trig_rise;
    logic [CNT_W-1:0] cnt_r;
    logic go_meas, go_out, go_err;
    logic run_r, ready_r, busy_r, judge_r, strobe_r, error_r;
    logic [DATA_W-1:0] data_r;

    pcch_sync #(.W(CODE_W + 1)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d({lnk.command_execute_trigger, lnk.command_code_inputs}),
        .q(pins_s)
    );

    assign trig_rise = pins_s[CODE_W] & ~trig_d_r;
    assign go_meas = trig_rise && state_r == PD_IDLE
        && pins_s[CODE_W-1:0] == CODE_MEAS_CLR;
    assign go_out = trig_rise && state_r == PD_IDLE
        && pins_s[CODE_W-1:0] == CODE_OUT_CLR;
    assign go_err = trig_rise && state_r == PD_IDLE
        && pins_s[CODE_W-1:0] == CODE_ERR_CLR;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trig_d_r <= 1'b0;
        end else begin
            trig_d_r <= pins_s[CODE_W];
        end
    end

    // Measurement clear sequence
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= PD_IDLE;
            cnt_r <= '0;
            busy_r <= 1'b0;
            ready_r <= 1'b1;
            meas_clear <= 1'b0;
        end else begin
            meas_clear <= go_meas;
            unique case (state_r)
                PD_IDLE: begin
                    if (go_meas) begin
                        state_r <= PD_BUSY;
                        cnt_r <= '0;
                        busy_r <= 1'b1;
                        ready_r <= 1'b0;
                    end
                end
                PD_BUSY: begin
                    if (cnt_r == CNT_W'(BUSY_CYCLES - 1)) begin
                        state_r <= PD_IDLE;
                        busy_r <= 1'b0;
                        ready_r <= 1'b1;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
            endcase
        end
    end

    // Judgement and result data; a new result beats a clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            judge_r <= 1'b0;
            data_r <= '0;
        end else if (res_load) begin
            judge_r <= res_judge;
            data_r <= res_data;
        end else if (go_out) begin
            judge_r <= 1'b0;
            data_r <= '0;
        end
    end

    // Strobe follows the output logic only, never a command
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strobe_r <= 1'b0;
            run_r <= 1'b0;
        end else begin
            strobe_r <= res_strobe;
            run_r <= run_screen;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            error_r <= 1'b0;
        end else if (err_raise) begin
            error_r <= 1'b1;
        end else if (go_err) begin
            error_r <= 1'b0;
        end
    end

    assign lnk.run = run_r;
    assign lnk.ready = ready_r;
    assign lnk.busy = busy_r;
    assign lnk.judge = judge_r;
    assign lnk.result_data_outputs = data_r;
    assign lnk.strobe = strobe_r;
    assign lnk.error = error_r;
endmodule
`default_nettype wire

// ### bench/pcch_asserts.sv
// Concurrent checks on the pins between host and device
`timescale 1ns/1ps
`default_nettype none
module pcch_asserts
    import pcch_pkg::*;
#(
    parameter int BUSY_CYCLES = 20,
    parameter int SETUP_CYCLES = 10
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Pins
    input wire logic [pcch_pkg::CODE_W-1:0] command_code_inputs,
    input wire logic command_execute_trigger,
    input wire logic ready,
    input wire logic busy,
    input wire logic judge,
    input wire logic [pcch_pkg::DATA_W-1:0] result_data_outputs,
    input wire logic error
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [20:0] busy_cnt_r;
    logic seen_busy_r;
    // Length of the current busy pulse
    always_ff @(posedge aclk) begin
        if (!aresetn || !busy) begin
            busy_cnt_r <= '0;
        end else begin
            busy_cnt_r <= busy_cnt_r + 21'h1;
        end
    end
    // Busy seen while the trigger is high
    always_ff @(posedge aclk) begin
        if (!aresetn || !command_execute_trigger) begin
            seen_busy_r <= 1'b0;
        end else if (busy) begin
            seen_busy_r <= 1'b1;
        end
    end
    a_busy_not_ready: assert property (busy |-> !ready)
        else $error("ready high while busy");
    a_busy_length: assert property ($fell(busy) |->
        busy_cnt_r == 21'(BUSY_CYCLES))
        else $error("busy pulse has wrong length");
    a_busy_meas_code: assert property ($rose(busy) |->
        command_code_inputs == CODE_MEAS_CLR)
        else $error("busy rose without measurement clear code");
    a_trig_setup: assert property ($rose(command_execute_trigger) |->
        command_code_inputs != CODE_NONE &&
        $past(command_code_inputs, SETUP_CYCLES) == command_code_inputs)
        else $error("trigger raised too early after code");
    a_code_hold: assert property (command_execute_trigger |->
        $stable(command_code_inputs))
        else $error("code changed while trigger high");
    a_meas_drop: assert property ($fell(command_execute_trigger) &&
        command_code_inputs == CODE_MEAS_CLR |-> seen_busy_r)
        else $error("trigger dropped before busy seen");
    a_out_drop: assert property ($fell(command_execute_trigger) &&
        command_code_inputs == CODE_OUT_CLR |->
        !judge || result_data_outputs == '0)
        else $error("trigger dropped before outputs cleared");
    a_err_drop: assert property ($fell(command_execute_trigger) &&
        command_code_inputs == CODE_ERR_CLR |-> !error && !$past(error))
        else $error("trigger dropped before error cleared");
    a_err_cause: assert property ($fell(error) |->
        command_code_inputs == CODE_ERR_CLR && command_execute_trigger)
        else $error("error fell without clear command");
endmodule
`default_nettype wire

// ### bench/pcch_tb.sv
// Testbench for both ends of the parallel clear command link
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
    comparisons++; \
    if ((g) !== (e)) begin \
        bad_count++; \
        $display("wrong value %s exp %0h got %0h", nm, e, g); \
    end \
end
module pcch_tb;
    import pcch_pkg::*;
    localparam int BUSY_N = 20;
    localparam int SETUP_N = 10;
    localparam int HOLD_N = 30;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic run_screen, res_load, res_judge, res_strobe, err_raise, meas_clear;
    logic [15:0] res_data;
    int bad_count, comparisons, meas_cnt, trig_len, trig_run;
    pcch_if lnk();
    pcch_host #(.SETUP_CYCLES(SETUP_N), .HOLD_CYCLES(HOLD_N)) pcch_host_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .irq(irq), .lnk(lnk));
    pcch_device #(.BUSY_CYCLES(BUSY_N)) pcch_device_inst (
        .aclk(aclk), .aresetn(aresetn), .lnk(lnk), .run_screen(run_screen),
        .res_load(res_load), .res_judge(res_judge), .res_data(res_data),
        .res_strobe(res_strobe), .err_raise(err_raise),
        .meas_clear(meas_clear));
    pcch_asserts #(.BUSY_CYCLES(BUSY_N), .SETUP_CYCLES(SETUP_N))
    pcch_asserts_inst (
        .aclk(aclk), .aresetn(aresetn),
        .command_code_inputs(lnk.command_code_inputs),
        .command_execute_trigger(lnk.command_execute_trigger),
        .ready(lnk.ready), .busy(lnk.busy), .judge(lnk.judge),
        .result_data_outputs(lnk.result_data_outputs), .error(lnk.error));
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    // Clear pulses and length of the last trigger pulse
    always @(posedge aclk) begin
        if (meas_clear) meas_cnt++;
        if (lnk.command_execute_trigger) begin
            trig_run++;
        end else if (trig_run != 0) begin
            trig_len = trig_run;
            trig_run = 0;
        end
    end
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        logic aw_t, w_t;
        aw_t = 1'b0;
        w_t = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_t && w_t)) begin
            @(posedge aclk);
            if (!aw_t && awready) begin
                aw_t = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_t && wready) begin
                w_t = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        `CHK("bresp", r, bresp)
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
        r = rresp;
    endtask
    // Issue a command and wait for its interrupt
    task automatic cmd(input logic [31:0] c, input logic [1:0] irq_exp);
        logic [31:0] d;
        logic [1:0] r;
        wr(ADDR_CTRL, c, RESP_OKAY);
        do @(posedge aclk); while (!irq);
        rd(ADDR_IRQ_STAT, d, r);
        `CHK("irq_stat", irq_exp, d[1:0])
        wr(ADDR_IRQ_STAT, {30'h0, irq_exp}, RESP_OKAY);
        repeat (3) @(posedge aclk);
        `CHK("irq", 1'b0, irq)
    endtask
    task automatic load(input logic j, input logic [15:0] dt);
        res_judge <= j;
        res_data <= dt;
        res_load <= 1'b1;
        @(posedge aclk);
        res_load <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask
    task automatic pins(input logic j, input logic [15:0] dt, input logic s,
                        input logic rdy, input logic b, input logic e);
        `CHK("judge", j, lnk.judge)
        `CHK("data", dt, lnk.result_data_outputs)
        `CHK("strobe", s, lnk.strobe)
        `CHK("ready", rdy, lnk.ready)
        `CHK("busy", b, lnk.busy)
        `CHK("error", e, lnk.error)
    endtask
    task automatic t_run();
        pins(1'b0, 16'h0000, 1'b0, 1'b1, 1'b0, 1'b0);
        run_screen <= 1'b1;
        repeat (3) @(posedge aclk);
        `CHK("run", 1'b1, lnk.run)
        run_screen <= 1'b0;
        repeat (3) @(posedge aclk);
        `CHK("run", 1'b0, lnk.run)
        run_screen <= 1'b1;
    endtask
    task automatic t_meas();
        int n;
        logic [31:0] d;
        logic [1:0] r;
        n = meas_cnt;
        cmd(32'h0000_0001, 2'h1);
        `CHK("meas_cnt", n + 1, meas_cnt)
        `CHK("short_trig", 1'b1, trig_len < HOLD_N)
        repeat (BUSY_N) @(posedge aclk);
        rd(ADDR_STATUS, d, r);
        `CHK("ready_busy", 2'b10, d[4:3])
        cmd(32'h0000_0011, 2'h1);
        `CHK("meas_cnt", n + 2, meas_cnt)
        `CHK("hold_len", 1'b1, trig_len >= HOLD_N && trig_len <= HOLD_N + 2)
        rd(ADDR_CTRL, d, r);
        `CHK("ctrl", 32'h0000_0011, d)
        repeat (BUSY_N) @(posedge aclk);
    endtask
    task automatic t_outs();
        logic [31:0] d;
        logic [1:0] r;
        load(1'b1, 16'hA5C3);
        res_strobe <= 1'b1;
        repeat (4) @(posedge aclk);
        cmd(32'h0000_0002, 2'h2);
        pins(1'b1, 16'hA5C3, 1'b1, 1'b1, 1'b0, 1'b0);
        rd(ADDR_DATA, d, r);
        `CHK("data_reg", 32'h0000_A5C3, d)
        res_strobe <= 1'b0;
        repeat (4) @(posedge aclk);
        cmd(32'h0000_0002, 2'h1);
        pins(1'b0, 16'h0000, 1'b0, 1'b1, 1'b0, 1'b0);
    endtask
    task automatic t_err();
        load(1'b1, 16'h3C5A);
        res_strobe <= 1'b1;
        err_raise <= 1'b1;
        @(posedge aclk);
        err_raise <= 1'b0;
        repeat (4) @(posedge aclk);
        `CHK("error", 1'b1, lnk.error)
        cmd(32'h0000_0003, 2'h1);
        pins(1'b1, 16'h3C5A, 1'b1, 1'b1, 1'b0, 1'b0);
        res_strobe <= 1'b0;
    endtask
    task automatic t_regs();
        logic [31:0] d;
        logic [1:0] r;
        wr(ADDR_IRQ_MASK, 32'h0, RESP_OKAY);
        res_strobe <= 1'b1;
        // Strobe needs three cycles to reach the host's synced copy
        repeat (4) @(posedge aclk);
        wr(ADDR_CTRL, 32'h0000_0002, RESP_OKAY);
        repeat (6) @(posedge aclk);
        `CHK("irq_masked", 1'b0, irq)
        rd(ADDR_IRQ_STAT, d, r);
        `CHK("irq_stat", 2'h2, d[1:0])
        wr(ADDR_IRQ_MASK, 32'h3, RESP_OKAY);
        repeat (3) @(posedge aclk);
        `CHK("irq_unmasked", 1'b1, irq)
        wr(ADDR_IRQ_STAT, 32'h2, RESP_OKAY);
        repeat (3) @(posedge aclk);
        `CHK("irq_cleared", 1'b0, irq)
        res_strobe <= 1'b0;
        rd(8'h14, d, r);
        `CHK("rresp", RESP_SLVERR, r)
        `CHK("rdata", 32'h0, d)
        wr(8'h14, 32'h1, RESP_SLVERR);
    endtask
    initial begin
        {aresetn, awvalid, wvalid, arvalid, res_load, res_judge} = '0;
        {run_screen, res_strobe, err_raise, awaddr, araddr} = '0;
        {bready, rready, wstrb, wdata, res_data} = {2'h3, 4'hF, 48'h0};
        {bad_count, comparisons, meas_cnt, trig_len, trig_run} = '0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        wr(ADDR_IRQ_MASK, 32'h3, RESP_OKAY);
        t_run();
        t_meas();
        t_outs();
        t_err();
        t_regs();
        summarize();
    end
    initial begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        summarize();
    end
endmodule
`default_nettype wire
